// ===== rtl/set_value_cmd.sv
// command interpreter for parameter-setting, loopback and diagnostic test commands
// Operation
// - code 81 loads buffer descriptor code
// - code 82 loads frame descriptor code
// - code 87 loads data buffer code
// - preset changes after init only via 83
// - preamble octet pattern sent bit 0 first
// - post-silence preamble count is field plus two
// - between-frame preamble count is field plus one
// - init loads preset from table offset 78
// - code 86 writes one-word private parameter
// - code 85 writes two-word private parameter
// - test commands accepted only while detached
// - test nibble decodes four test kinds
// - code CC selects internal loopback, C4 turns it off
// - internal loopback off after reset
// - loopback routes tx internally, pins send silence
// - host test copies 34 bytes to second half
// - host test end sets done at 9C
// - set group 1000_0sss selects function
`timescale 1ns/1ps
`default_nettype none
module set_value_cmd (
	input  wire logic                         mclk_in,
	input  wire logic                         resetn_in,
	input  wire logic                         cmd_valid_in,
	input  wire logic [7:0]                   cmd_code_in,
	input  wire set_value_pkg::param_words_t  param_in,
	input  wire logic                         init_start_in,
	input  wire logic [31:0]                  init_base_in,
	input  wire logic [3:0]                   init_fc_in,
	input  wire logic                         detached_state_in,
	input  wire logic                         mem_ack_in,
	input  wire logic [15:0]                  mem_rdata_in,
	input  wire logic [2:0]                   tx_sym_int_in,
	input  wire logic [2:0]                   rx_sym_pin_in,
	input  wire logic                         pre_step_in,
	output var  set_value_pkg::mem_req_t      mem_out,
	output var  set_value_pkg::priv_wr_t      priv_wr_out,
	output var  set_value_pkg::test_start_t   test_start_out,
	output var  set_value_pkg::preamble_cfg_t pre_cfg_out,
	output var  logic                         pre_bit_out,
	output var  logic [3:0]                   bd_fc_out,
	output var  logic [3:0]                   fd_fc_out,
	output var  logic [3:0]                   data_fc_out,
	output var  logic                         loop_int_out,
	output var  logic [2:0]                   tx_sym_pin_out,
	output var  logic [2:0]                   rx_sym_out,
	output var  logic                         busy_out,
	output var  logic                         done_out
);
	import set_value_pkg::*;

	ctl_state_t  st_ff;
	ctl_state_t  nxt_st;
	logic        take;
	logic        is_set;
	logic        is_test;
	logic        is_loop;
	logic [2:0]  sel;
	logic [3:0]  tsel;
	logic        tx_test;
	logic        ram_we;
	logic [15:0] ram_rdata;
	logic [31:0] word_off;

	// ==========================================================
	// buffer for the host interface test words
	hit_buffer_ram u_ram (
		.mclk_in   (mclk_in),
		.we_in     (ram_we),
		.waddr_in  (st_ff.idx),
		.wdata_in  (mem_rdata_in),
		.raddr_in  (st_ff.idx),
		.rdata_out (ram_rdata)
	);

	// ==========================================================
	// command decode; commands arriving while busy are dropped
	always_comb begin
		take     = cmd_valid_in && (st_ff.fsm == ST_IDLE);
		sel      = cmd_code_in[2:0];
		tsel     = cmd_code_in[3:0];
		is_set   = (cmd_code_in[7:3] == SET_GROUP);
		is_test  = (cmd_code_in[7:4] == TEST_GROUP) && detached_state_in;
		is_loop  = (cmd_code_in[7:4] == LOOP_GROUP) && (sel == LOOP_LOW);
		tx_test  = (tsel[3:2] == 2'b01) && !tsel[0];
		ram_we   = (st_ff.fsm == ST_HIT_RD) && st_ff.mem.req && mem_ack_in;
		word_off = {26'h0, st_ff.idx, 1'b0};
	end

	// ==========================================================
	// next state
	always_comb begin
		nxt_st            = st_ff;
		nxt_st.done       = 1'b0;
		nxt_st.priv.valid = 1'b0;
		nxt_st.test.valid = 1'b0;
		// preamble fields are biased: stored counts are minus two and minus one
		nxt_st.pre_cfg.pattern      = st_ff.preset[7:0];
		nxt_st.pre_cfg.post_silence = {1'b0, st_ff.preset[10:8]} + POST_SIL_BIAS;
		nxt_st.pre_cfg.between      = {1'b0, st_ff.preset[15:11]} + BETWEEN_BIAS;
		// serialise the pattern, lowest bit of the octet first
		if (pre_step_in) begin
			nxt_st.pre_bit = st_ff.preset[st_ff.bit_idx];
			nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
		end
		// pin receive path is synchronised before the loopback mux reads it
		nxt_st.rx_s1  = rx_sym_pin_in;
		nxt_st.rx_s2  = st_ff.rx_s1;
		nxt_st.rx_sym = st_ff.loop ? tx_sym_int_in : st_ff.rx_s2;
		nxt_st.tx_pin = st_ff.loop ? SILENCE_SYM : tx_sym_int_in;

		case (st_ff.fsm)
			ST_IDLE: begin
				if (init_start_in) begin
					nxt_st.base    = init_base_in;
					nxt_st.base_fc = init_fc_in;
					nxt_st.mem     = '{req: 1'b1, we: 1'b0, fc: init_fc_in,
					                   addr: init_base_in + PRESET_OFFSET, wdata: 16'h0000};
					nxt_st.fsm     = ST_INIT_RD;
				end else if (take && is_set) begin
					// select values 0 and 4 fall through and leave everything alone
					nxt_st.fsm = ST_DONE_WR;
					case (sel)
						SEL_BD_FC:    nxt_st.bd_fc   = param_in.w0[3:0];
						SEL_FD_FC:    nxt_st.fd_fc   = param_in.w0[3:0];
						SEL_DATA_FC:  nxt_st.data_fc = param_in.w0[3:0];
						SEL_PRESET:   nxt_st.preset  = param_in.w0;
						SEL_ONE_WORD: nxt_st.priv    = '{valid: 1'b1, two: 1'b0,
						                                 opcode: param_in.w0[7:0],
						                                 data: {16'h0000, param_in.w1}};
						SEL_TWO_WORD: nxt_st.priv    = '{valid: 1'b1, two: 1'b1,
						                                 opcode: param_in.w0[7:0],
						                                 data: {param_in.w1, param_in.w2}};
						default:      nxt_st.fsm     = ST_IDLE;
					endcase
				end else if (take && is_loop) begin
					nxt_st.loop = cmd_code_in[LOOP_BIT];
					nxt_st.fsm  = ST_DONE_WR;
				end else if (take && is_test) begin
					if (tsel == TEST_HOST) begin
						nxt_st.buf_fc  = param_in.w0[3:0];
						nxt_st.buf_ptr = {param_in.w1, param_in.w2};
						nxt_st.idx     = 5'h00;
						nxt_st.fsm     = ST_HIT_RD;
					end else if ((tsel == TEST_RX) || (tsel == TEST_DUPLEX) || tx_test) begin
						nxt_st.test = '{valid: 1'b1, sel: tsel};
						nxt_st.fsm  = ST_DONE_WR;
					end
				end
			end
			ST_INIT_RD: begin
				if (mem_ack_in) begin
					nxt_st.preset  = mem_rdata_in;
					nxt_st.mem.req = 1'b0;
					nxt_st.fsm     = ST_IDLE;
				end
			end
			ST_HIT_RD: begin
				// one word per request; req drops for a cycle between words
				if (!st_ff.mem.req) begin
					nxt_st.mem = '{req: 1'b1, we: 1'b0, fc: st_ff.buf_fc,
					               addr: st_ff.buf_ptr + word_off, wdata: 16'h0000};
				end else if (mem_ack_in) begin
					nxt_st.mem.req = 1'b0;
					if (st_ff.idx == HIT_WORDS - 5'h01) begin
						nxt_st.idx = 5'h00;
						nxt_st.fsm = ST_HIT_FETCH;
					end else begin
						nxt_st.idx = st_ff.idx + 5'h01;
					end
				end
			end
			ST_HIT_FETCH: nxt_st.fsm = ST_HIT_LOAD;  // ram read latency
			ST_HIT_LOAD: begin
				// index 17 is the indication word, written as zero
				nxt_st.mem = '{req: 1'b1, we: 1'b1, fc: st_ff.buf_fc,
				               addr: st_ff.buf_ptr + HIT_RET_OFFSET + word_off,
				               wdata: ram_rdata};
				nxt_st.fsm = ST_HIT_WR;
			end
			ST_HIT_WR: begin
				if (mem_ack_in) begin
					nxt_st.mem.req = 1'b0;
					nxt_st.mem.we  = 1'b0;
					if (st_ff.idx == HIT_WORDS) begin
						nxt_st.fsm = ST_DONE_WR;
					end else begin
						nxt_st.idx = st_ff.idx + 5'h01;
						nxt_st.fsm = ST_HIT_FETCH;
					end
				end
			end
			ST_DONE_WR: begin
				if (!st_ff.mem.req) begin
					nxt_st.mem = '{req: 1'b1, we: 1'b1, fc: st_ff.base_fc,
					               addr: st_ff.base + RESULT_OFFSET, wdata: DONE_WORD};
				end else if (mem_ack_in) begin
					nxt_st.mem.req = 1'b0;
					nxt_st.mem.we  = 1'b0;
					nxt_st.done    = 1'b1;
					nxt_st.fsm     = ST_IDLE;
				end
			end
			default: nxt_st.fsm = ST_IDLE;
		endcase
		nxt_st.busy = (nxt_st.fsm != ST_IDLE);
	end

	// ==========================================================
	// state register; loopback starts disabled
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_ff         <= '0;
			st_ff.fsm     <= ST_IDLE;
			st_ff.bd_fc   <= FC_RESET;
			st_ff.fd_fc   <= FC_RESET;
			st_ff.data_fc <= FC_RESET;
			st_ff.preset  <= PRESET_RESET;
			st_ff.loop    <= 1'b0;
			st_ff.tx_pin  <= SILENCE_SYM;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	always_comb begin
		mem_out        = st_ff.mem;
		priv_wr_out    = st_ff.priv;
		test_start_out = st_ff.test;
		pre_cfg_out    = st_ff.pre_cfg;
		pre_bit_out    = st_ff.pre_bit;
		bd_fc_out      = st_ff.bd_fc;
		fd_fc_out      = st_ff.fd_fc;
		data_fc_out    = st_ff.data_fc;
		loop_int_out   = st_ff.loop;
		tx_sym_pin_out = st_ff.tx_pin;
		rx_sym_out     = st_ff.rx_sym;
		busy_out       = st_ff.busy;
		done_out       = st_ff.done;
	end

	// ==========================================================
	// checks
	chk_bd_code_load: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && sel == SEL_BD_FC)
		|=> (bd_fc_out == $past(param_in.w0[3:0])) && (fd_fc_out == $past(fd_fc_out)))
		else $error("buffer descriptor code not taken");
	chk_fd_code_load: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && sel == SEL_FD_FC)
		|=> fd_fc_out == $past(param_in.w0[3:0]))
		else $error("frame descriptor code not taken");
	chk_data_code_load: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && sel == SEL_DATA_FC)
		|=> data_fc_out == $past(param_in.w0[3:0]))
		else $error("data buffer code not taken");
	chk_preset_fields: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && sel == SEL_PRESET)
		|=> ##1 (pre_cfg_out.post_silence == {1'b0, $past(param_in.w0[10:8], 2)} + 4'h2)
		&& (pre_cfg_out.between == {1'b0, $past(param_in.w0[15:11], 2)} + 6'h01))
		else $error("preamble counts wrong after preset command");
	chk_two_word: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && sel == SEL_TWO_WORD)
		|=> priv_wr_out.valid && priv_wr_out.two
		&& (priv_wr_out.data == {$past(param_in.w1), $past(param_in.w2)}))
		else $error("two word value not passed");
	chk_test_detached_state: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		test_start_out.valid |-> $past(detached_state_in))
		else $error("test started while not detached");
	chk_unknown_ignored: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(take && !init_start_in && is_set && (sel == 3'h0 || sel == 3'h4))
		|=> (busy_out == 1'b0) [*2])
		else $error("unknown set command was acted on");
	chk_loop_silence: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		loop_int_out |=> tx_sym_pin_out == SILENCE_SYM)
		else $error("pins not silent in internal loopback");
	chk_done_word: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(st_ff.fsm == ST_DONE_WR && mem_out.req)
		|-> mem_out.we && (mem_out.addr == st_ff.base + RESULT_OFFSET)
		&& (mem_out.wdata == DONE_WORD))
		else $error("done word written wrongly");
	chk_hit_ret_addr: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(st_ff.fsm == ST_HIT_WR && mem_out.req)
		|-> mem_out.addr == st_ff.buf_ptr + HIT_RET_OFFSET + word_off)
		else $error("host test write back at wrong address");

endmodule : set_value_cmd
`default_nettype wire

// ===== shared/set_value_pkg.sv
// shared constants, states and carrier types for the set-value and test command block
package set_value_pkg;

	// ==========================================================
	// command codes and decode fields
	localparam logic [4:0] SET_GROUP    = 5'h10;  // 1000_0sss
	localparam logic [3:0] TEST_GROUP   = 4'hb;   // 1011_test_select_nibble
	localparam logic [3:0] LOOP_GROUP   = 4'hc;   // 1100_x100
	localparam logic [2:0] LOOP_LOW     = 3'h4;
	localparam int         LOOP_BIT     = 3;
	localparam logic [2:0] SEL_BD_FC    = 3'h1;
	localparam logic [2:0] SEL_FD_FC    = 3'h2;
	localparam logic [2:0] SEL_PRESET   = 3'h3;
	localparam logic [2:0] SEL_TWO_WORD = 3'h5;
	localparam logic [2:0] SEL_ONE_WORD = 3'h6;
	localparam logic [2:0] SEL_DATA_FC  = 3'h7;
	localparam logic [3:0] TEST_RX      = 4'h0;
	localparam logic [3:0] TEST_DUPLEX  = 4'h8;
	localparam logic [3:0] TEST_HOST    = 4'hc;

	// ==========================================================
	// table offsets, buffer layout, reset values
	localparam logic [31:0] PRESET_OFFSET  = 32'h78;
	localparam logic [31:0] RESULT_OFFSET  = 32'h9c;
	localparam logic [31:0] HIT_RET_OFFSET = 32'h22;  // second half at byte 34
	localparam logic [4:0]  HIT_WORDS      = 5'h11;   // 34 bytes as 17 words
	localparam logic [15:0] DONE_WORD      = 16'h0001;
	localparam logic [3:0]  FC_RESET       = 4'h0;
	localparam logic [15:0] PRESET_RESET   = 16'h0000;
	localparam logic [2:0]  SILENCE_SYM    = 3'h0;
	localparam logic [3:0]  POST_SIL_BIAS  = 4'h2;
	localparam logic [5:0]  BETWEEN_BIAS   = 6'h01;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [15:0] w2;
		logic [15:0] w1;
		logic [15:0] w0;
	} param_words_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [3:0]  fc;
		logic [31:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        valid;
		logic        two;
		logic [7:0]  opcode;
		logic [31:0] data;
	} priv_wr_t;

	typedef struct packed {
		logic [5:0] between;
		logic [3:0] post_silence;
		logic [7:0] pattern;
	} preamble_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] sel;
	} test_start_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_INIT_RD, ST_HIT_RD, ST_HIT_FETCH, ST_HIT_LOAD, ST_HIT_WR, ST_DONE_WR
	} fsm_t;

	typedef struct packed {
		fsm_t          fsm;
		logic          busy;
		logic          done;
		logic [3:0]    bd_fc;
		logic [3:0]    fd_fc;
		logic [3:0]    data_fc;
		logic [15:0]   preset;
		logic          loop;
		logic [4:0]    idx;
		logic [3:0]    buf_fc;
		logic [31:0]   buf_ptr;
		logic [31:0]   base;
		logic [3:0]    base_fc;
		mem_req_t      mem;
		priv_wr_t      priv;
		test_start_t   test;
		preamble_cfg_t pre_cfg;
		logic [2:0]    bit_idx;
		logic          pre_bit;
		logic [2:0]    tx_pin;
		logic [2:0]    rx_sym;
		logic [2:0]    rx_s1;
		logic [2:0]    rx_s2;
	} ctl_state_t;

endpackage : set_value_pkg

// ===== rtl/hit_buffer_ram.sv
// small word store holding the host interface test data between read and write back
`timescale 1ns/1ps
`default_nettype none
module hit_buffer_ram (
	input  wire logic        mclk_in,
	input  wire logic        we_in,
	input  wire logic [4:0]  waddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [4:0]  raddr_in,
	output var  logic [15:0] rdata_out
);
	import set_value_pkg::*;

	logic [15:0] mem_ff [0:16];

	// ==========================================================
	// write port, guarded against the index running one past the end
	always_ff @(posedge mclk_in) begin
		if (we_in && (waddr_in < HIT_WORDS)) begin
			mem_ff[waddr_in] <= wdata_in;
		end
	end

	// registered read; out of range reads give zero for the trailer word
	always_ff @(posedge mclk_in) begin
		if (raddr_in < HIT_WORDS) begin
			rdata_out <= mem_ff[raddr_in];
		end else begin
			rdata_out <= 16'h0000;
		end
	end

endmodule : hit_buffer_ram
`default_nettype wire

// ===== test/mem_partner.sv
// memory model answering the command block's word requests
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
	input  wire set_value_pkg::mem_req_t mem_in,
	input  wire logic                    mclk_in,
	input  wire logic                    resetn_in,
	output var  logic                    ack_out,
	output var  logic [15:0]             rdata_out
);
	import set_value_pkg::*;
	logic [15:0] mem [logic [31:0]];
	logic [3:0]  fc_seen [logic [31:0]];
	logic [1:0]  wait_ff;
	logic        slow_ff;
	// ==========================================================
	// answer alternates prompt and slow; data scrambled outside an ack so stale words never pass
	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_out <= 1'b0;
			wait_ff <= 2'h0;
			slow_ff <= 1'b0;
			rdata_out <= 16'h5a5a;
		end else if (ack_out || !mem_in.req) begin
			ack_out <= 1'b0;
			wait_ff <= 2'h0;
			rdata_out <= ~rdata_out;
		end else if (wait_ff < {slow_ff, 1'b0}) begin
			wait_ff <= wait_ff + 2'h1;
			rdata_out <= ~rdata_out;
		end else begin
			ack_out <= 1'b1;
			slow_ff <= ~slow_ff;
			// the space code of each write is kept so the bench can judge it
			if (mem_in.we) begin
				mem[mem_in.addr] = mem_in.wdata;
				fc_seen[mem_in.addr] = mem_in.fc;
			end else
				rdata_out <= mem.exists(mem_in.addr) ? mem[mem_in.addr] : 16'h0000;
		end
	end
endmodule : mem_partner
`default_nettype wire

// ===== test/set_value_and_test_commands_test.sv
// self-checking bench for the set-value and test command block
`timescale 1ns/1ps
`default_nettype none
module set_value_and_test_commands_test;
	import set_value_pkg::*;
	localparam logic [31:0] BASE = 32'h0000_0100;
	localparam logic [31:0] PTR  = 32'h0000_0400;
	logic mclk_in = 1'b0, resetn_in = 1'b0, cmd_valid = 1'b0, init_start = 1'b0;
	logic detached = 1'b0, mem_ack, pre_step = 1'b0, pre_bit, loop_int, busy, done;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] mem_rdata;
	logic [2:0] tx_int = 3'h5, rx_pin = 3'h3, tx_pin, rx_sym;
	logic [3:0] bd_fc, fd_fc, data_fc;
	param_words_t param = '0;
	mem_req_t mem_o;
	priv_wr_t priv_o, priv_seen;
	test_start_t test_o, test_seen;
	preamble_cfg_t pre_cfg;
	int fail_count = 0, samples_checked = 0, cycles = 0, done_cnt = 0, priv_cnt = 0;
	int test_cnt = 0;

	// ==========================================================
	// design, memory partner and clock
	set_value_cmd uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
		.cmd_code_in(cmd_code), .param_in(param), .init_start_in(init_start),
		.init_base_in(BASE), .init_fc_in(4'h3), .detached_state_in(detached),
		.mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .tx_sym_int_in(tx_int),
		.rx_sym_pin_in(rx_pin), .pre_step_in(pre_step), .mem_out(mem_o),
		.priv_wr_out(priv_o), .test_start_out(test_o), .pre_cfg_out(pre_cfg),
		.pre_bit_out(pre_bit), .bd_fc_out(bd_fc), .fd_fc_out(fd_fc),
		.data_fc_out(data_fc), .loop_int_out(loop_int), .tx_sym_pin_out(tx_pin),
		.rx_sym_out(rx_sym), .busy_out(busy), .done_out(done));
	mem_partner u_mem (.mem_in(mem_o), .mclk_in(mclk_in), .resetn_in(resetn_in),
		.ack_out(mem_ack), .rdata_out(mem_rdata));
	always #20 mclk_in = ~mclk_in;

	// ==========================================================
	// pulse catchers and hang guard
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (done === 1'b1) done_cnt <= done_cnt + 1;
		if (priv_o.valid === 1'b1) begin
			priv_cnt <= priv_cnt + 1;
			priv_seen <= priv_o;
		end
		if (test_o.valid === 1'b1) begin
			test_cnt <= test_cnt + 1;
			test_seen <= test_o;
		end
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [17:0] cfg_of(input logic [15:0] p);
		return {{1'b0, p[15:11]} + BETWEEN_BIAS, {1'b0, p[10:8]} + POST_SIL_BIAS, p[7:0]};
	endfunction : cfg_of

	// host clears the done word before each command so polling means something
	task automatic run_cmd(input logic [7:0] code, input logic [15:0] w0, w1, w2);
		int n;
		u_mem.mem[BASE + RESULT_OFFSET] = 16'h0000;
		@(posedge mclk_in);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		param <= '{w2: w2, w1: w1, w0: w0};
		@(posedge mclk_in);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 3000);
		repeat (2) @(posedge mclk_in);
		#1;
	endtask : run_cmd

	// ==========================================================
	// scenarios
	task automatic t_init;
		int d;
		d = done_cnt;
		check({loop_int, bd_fc, fd_fc, data_fc}, 13'h0);
		check(tx_pin, tx_int);
		check(pre_cfg, cfg_of(PRESET_RESET));
		u_mem.mem[BASE + PRESET_OFFSET] = 16'h8a55;
		@(posedge mclk_in);
		init_start <= 1'b1;
		@(posedge mclk_in);
		init_start <= 1'b0;
		repeat (12) @(posedge mclk_in);
		#1;
		check(pre_cfg, cfg_of(16'h8a55));
		check(done_cnt, d);
		for (int k = 0; k < 9; k++) begin
			@(posedge mclk_in);
			pre_step <= 1'b1;
			@(posedge mclk_in);
			pre_step <= 1'b0;
			#1;
			check(pre_bit, 16'h8a55 >> (k % 8) & 1);
		end
	endtask : t_init

	task automatic t_set;
		logic [7:0] codes [5] = '{8'h81, 8'h82, 8'h87, 8'h80, 8'h84};
		int d;
		for (int i = 0; i < 5; i++) begin
			d = done_cnt;
			run_cmd(codes[i], 16'hfff0 | 16'(i + 9), 16'h0, 16'h0);
			check({bd_fc, fd_fc, data_fc}, {4'h9, i > 0 ? 4'ha : 4'h0, i > 1 ? 4'hb : 4'h0});
			check(done_cnt - d, i < 3);
			check(u_mem.mem[BASE + RESULT_OFFSET], i < 3 ? DONE_WORD : 16'h0);
		end
		run_cmd(8'h83, 16'h1b2c, 16'h0, 16'h0);
		check(pre_cfg, cfg_of(16'h1b2c));
		run_cmd(8'h86, 16'h000e, 16'h1234, 16'h0);
		check(priv_seen, {1'b1, 1'b0, 8'h0e, 32'h0000_1234});
		run_cmd(8'h85, 16'h002a, 16'hdead, 16'hbeef);
		check(priv_seen, {1'b1, 1'b1, 8'h2a, 32'hdead_beef});
		check(priv_cnt, 2);
	endtask : t_set

	// receive clock is this bench's own clock, so looped tests still see one
	task automatic t_loop;
		run_cmd(8'hcc, 16'h0, 16'h0, 16'h0);
		@(posedge mclk_in);
		tx_int <= 3'h6;
		repeat (3) @(posedge mclk_in);
		#1;
		check({loop_int, tx_pin, rx_sym}, {1'b1, SILENCE_SYM, 3'h6});
		run_cmd(8'hc4, 16'h0, 16'h0, 16'h0);
		repeat (3) @(posedge mclk_in);
		#1;
		check({loop_int, tx_pin, rx_sym}, {1'b0, 3'h6, rx_pin});
		// pin change must take three edges: two synchroniser stages and the output flop
		@(posedge mclk_in);
		rx_pin <= 3'h1;
		repeat (2) @(posedge mclk_in);
		#1;
		check(rx_sym, 3'h3);
		@(posedge mclk_in);
		#1;
		check(rx_sym, 3'h1);
	endtask : t_loop

	// host supplies buffer code and pointer before the host interface
	task automatic t_test;
		logic [7:0] codes [6] = '{8'hb0, 8'hb4, 8'hb6, 8'hb8, 8'hb1, 8'hba};
		int c;
		run_cmd(8'hb0, 16'h0, 16'h0, 16'h0);
		check(test_cnt, 0);
		@(posedge mclk_in);
		detached <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			c = test_cnt;
			run_cmd(codes[i], 16'h0, 16'h0, 16'h0);
			check(test_cnt - c, i < 4);
			if (i < 4) check(test_seen.sel, codes[i][3:0]);
		end
		for (int k = 0; k < 17; k++) u_mem.mem[PTR + 2 * k] = 16'h3c00 ^ (k * 16'h0107);
		run_cmd(8'hbc, 16'h0005, PTR[31:16], PTR[15:0]);
		for (int k = 0; k < 17; k++)
			check(u_mem.mem[PTR + 34 + 2 * k], 16'h3c00 ^ (k * 16'h0107));
		check(u_mem.mem[PTR + 68], 16'h0);
		check(u_mem.fc_seen[PTR + 34], 4'h5);
		check(u_mem.mem[BASE + RESULT_OFFSET], DONE_WORD);
		check(u_mem.fc_seen[BASE + RESULT_OFFSET], 4'h3);
	endtask : t_test

	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// ==========================================================
	// main sequence; code commands skipped would be legal if codes unused
	initial begin
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		#1;
		t_init();
		t_set();
		t_loop();
		t_test();
		end_of_test();
	end
endmodule : set_value_and_test_commands_test
`default_nettype wire
